//--- src/gp_pkg.sv
// Constants and carriers of the general pin configuration unit
package gp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] CFG_INDEX = 16'h4043;
    localparam logic [15:0] LVL_INDEX = 16'h4044;
    localparam logic [29:0] CFG_WORD = {14'h0000, CFG_INDEX};
    localparam logic [29:0] LVL_WORD = {14'h0000, LVL_INDEX};
    localparam logic [15:0] CFG_RESET = 16'hA400;
    localparam logic [15:0] CFG_WMASK = 16'hFE8F;
    // Field positions
    localparam int DIR_POS = 15;
    localparam int PULL_POS = 13;
    localparam int EDGE_POS = 12;
    localparam int DOM_POS = 11;
    localparam int POL_POS = 10;
    localparam int OD_POS = 9;
    localparam int ENA_POS = 7;
    localparam int FN_POS = 0;
    // Pull codes
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Input function codes
    localparam logic [3:0] FI_GPIO_LONG = 4'h0;
    localparam logic [3:0] FI_GPIO = 4'h1;
    localparam logic [3:0] FI_PWR_ONOFF = 4'h2;
    localparam logic [3:0] FI_SLEEP_WAKE = 4'h3;
    localparam logic [3:0] FI_SLEEP_WAKE_LONG = 4'h4;
    localparam logic [3:0] FI_SLEEP = 4'h5;
    localparam logic [3:0] FI_PWR_ON = 4'h6;
    localparam logic [3:0] FI_WDOG = 4'h7;
    localparam logic [3:0] FI_VSCALE1 = 4'h8;
    localparam logic [3:0] FI_VSCALE2 = 4'h9;
    localparam logic [3:0] FI_HW_EN1 = 4'hA;
    localparam logic [3:0] FI_HW_EN2 = 4'hB;
    localparam logic [3:0] FI_HW_CTL1 = 4'hC;
    localparam logic [3:0] FI_HW_CTL2 = 4'hD;
    localparam logic [3:0] FI_HW_CTL1_LONG = 4'hE;
    localparam logic [3:0] FI_HW_CTL2_LONG = 4'hF;
    // Output function codes
    localparam logic [3:0] FO_LEVEL = 4'h0;
    localparam logic [3:0] FO_CLK_32K = 4'h1;
    localparam logic [3:0] FO_ON_STATE = 4'h2;
    localparam logic [3:0] FO_SLEEP_STATE = 4'h3;
    localparam logic [3:0] FO_STATE_CHANGE = 4'h4;
    localparam logic [3:0] FO_RSV_LO = 4'h5;
    localparam logic [3:0] FO_RSV_HI = 4'h7;
    localparam logic [3:0] FO_VSCALE_DONE1 = 4'h8;
    localparam logic [3:0] FO_VSCALE_DONE2 = 4'h9;
    localparam logic [3:0] FO_EXT_EN1 = 4'hA;
    localparam logic [3:0] FO_EXT_EN2 = 4'hB;
    localparam logic [3:0] FO_SYS_OK = 4'hC;
    localparam logic [3:0] FO_PWR_OK = 4'hD;
    localparam logic [3:0] FO_CLK_2M = 4'hE;
    localparam logic [3:0] FO_AUX_RST = 4'hF;

    typedef struct packed {
        logic dir;
        logic [1:0] pull;
        logic edge_both;
        logic dom;
        logic pol;
        logic od;
        logic rsv8;
        logic ena;
        logic [2:0] rsv4;
        logic [3:0] fn;
    } cfg_t;

    // Requests passed to the power state logic
    typedef struct packed {
        logic gpio_level;
        logic long_db;
        logic pwr_onoff;
        logic sleep_wake;
        logic sleep;
        logic pwr_on;
        logic wdog_kick;
        logic [1:0] vscale_sel;
        logic [1:0] hw_en;
        logic [1:0] hw_ctl;
    } req_t;

    // Internal sources for output functions
    typedef struct packed {
        logic clk_32k;
        logic on_state;
        logic sleep_state;
        logic state_change;
        logic [1:0] vscale_done;
        logic [1:0] ext_en;
        logic sys_ok;
        logic pwr_ok;
        logic clk_2m;
        logic aux_rst;
    } src_t;

    typedef struct packed {
        cfg_t cfg;
        logic out_lvl;
        logic sync1;
        logic sync2;
        logic prev;
        logic irq;
        logic pin_o;
        logic pin_oe_n;
        req_t req;
        logic aw_got;
        logic [31:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } st_t;

    localparam st_t ST_RESET = '{cfg: CFG_RESET, pin_oe_n: 1'b1, default: '0};
endpackage

//--- src/gp_pin_unit.sv
// General pin configuration and function select with AXI4-Lite slave
`timescale 1ns/100ps

// Function
// RQ1 - Pull field: none, down, up; resets down
// RQ2 - Single edge interrupt follows polarity setting
// RQ3 - Edge mode one: interrupt on both edges
// RQ4 - Supply bit selects host or power input
// RQ5 - Polarity one active high, zero inverts
// RQ6 - Open drain bit: CMOS or open drain
// RQ7 - Enable zero keeps pin tri-stated
// RQ8 - Direction picks list for function code
// RQ9 - Input codes 0,1: general input, debounce
// RQ10 - Input codes 2,5,6: power requests
// RQ11 - Input codes 3,4: sleep/wake request
// RQ12 - Input code 7: watchdog kick input
// RQ13 - Codes 8-11: voltage scaling, hardware enables
// RQ14 - Codes 12-15: hardware control inputs
// RQ15 - Output codes 0,1: level, slow clock
// RQ16 - Output codes 2-4: power state signals
// RQ17 - Output codes 8,9: voltage scaling done
// RQ18 - Output codes 10,11: external power enables
// RQ19 - Output codes 12,13: supply and power good
// RQ20 - Output codes 14,15: fast clock, reset
// RQ21 - Disabled pin: no interrupt, no request
// RQ22 - Reserved output codes drive inactive level
module gp_pin_unit (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_n,
    output logic pull_up_en,
    output logic pull_down_en,
    output logic supply_sel,
    input wire gp_pkg::src_t src,
    output gp_pkg::req_t req,
    output logic pin_irq
);

    gp_pkg::st_t st_ff;
    gp_pkg::st_t nxt_st;
    logic ena_w;
    logic dir_w;
    logic pol_w;
    logic od_w;
    logic edge_w;
    logic rise_w;
    logic fall_w;
    logic act_w;
    logic [3:0] fn_w;
    logic aw_hit;
    logic w_hit;

    ////////////////////////////////////////////////////////////////////////
    // Field views

    assign ena_w = st_ff.cfg.ena;
    assign dir_w = st_ff.cfg.dir;
    assign pol_w = st_ff.cfg.pol;
    assign od_w = st_ff.cfg.od;
    assign edge_w = st_ff.cfg.edge_both;
    assign fn_w = st_ff.cfg.fn;
    assign rise_w = st_ff.sync2 & ~st_ff.prev;
    assign fall_w = ~st_ff.sync2 & st_ff.prev;
    assign act_w = pol_w ? st_ff.sync2 : ~st_ff.sync2; // [RQ5]

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign awready = ~st_ff.aw_got & ~st_ff.bvalid;
    assign wready = ~st_ff.w_got & ~st_ff.bvalid;
    assign arready = ~st_ff.rvalid;
    assign aw_hit = awvalid & awready;
    assign w_hit = wvalid & wready;
    assign bvalid = st_ff.bvalid;
    assign bresp = st_ff.bresp;
    assign rvalid = st_ff.rvalid;
    assign rdata = st_ff.rdata;
    assign rresp = st_ff.rresp;
    assign pin_o = st_ff.pin_o;
    assign pin_oe_n = st_ff.pin_oe_n;
    assign pin_irq = st_ff.irq;
    assign req = st_ff.req;
    assign pull_up_en = (st_ff.cfg.pull == gp_pkg::PULL_UP); // [RQ1]
    assign pull_down_en = (st_ff.cfg.pull == gp_pkg::PULL_DOWN); // [RQ1]
    assign supply_sel = st_ff.cfg.dom; // [RQ4]

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic lvl;
        logic drive;
        logic in_on;
        logic out_on;
        logic [31:0] wa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic [15:0] m;
        lvl = 1'b0;
        drive = 1'b0;
        in_on = 1'b0;
        out_on = 1'b0;
        wa = 32'h0000_0000;
        wd = 32'h0000_0000;
        ws = 4'h0;
        m = 16'h0000;
        nxt_st = st_ff;

        // Pin synchroniser and edge history
        nxt_st.sync1 = pin_i;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev = st_ff.sync2;

        in_on = ena_w & dir_w; // [RQ8] [RQ21]
        out_on = ena_w & ~dir_w; // [RQ7] [RQ8]

        // Interrupt edge select
        if (!in_on) begin
            nxt_st.irq = 1'b0; // [RQ21]
        end else if (edge_w) begin
            nxt_st.irq = rise_w | fall_w; // [RQ3]
        end else begin
            nxt_st.irq = pol_w ? rise_w : fall_w; // [RQ2]
        end

        // Input functions
        nxt_st.req = '0;
        if (in_on) begin
            case (fn_w)
                gp_pkg::FI_GPIO_LONG: begin
                    nxt_st.req.gpio_level = act_w; // [RQ9]
                    nxt_st.req.long_db = 1'b1; // [RQ9]
                end
                gp_pkg::FI_GPIO: begin
                    nxt_st.req.gpio_level = act_w; // [RQ9]
                end
                gp_pkg::FI_PWR_ONOFF: begin
                    nxt_st.req.pwr_onoff = act_w; // [RQ10]
                end
                gp_pkg::FI_SLEEP_WAKE: begin
                    nxt_st.req.sleep_wake = act_w; // [RQ11]
                end
                gp_pkg::FI_SLEEP_WAKE_LONG: begin
                    nxt_st.req.sleep_wake = act_w; // [RQ11]
                    nxt_st.req.long_db = 1'b1; // [RQ11]
                end
                gp_pkg::FI_SLEEP: begin
                    nxt_st.req.sleep = act_w; // [RQ10]
                end
                gp_pkg::FI_PWR_ON: begin
                    nxt_st.req.pwr_on = act_w; // [RQ10]
                end
                gp_pkg::FI_WDOG: begin
                    nxt_st.req.wdog_kick = act_w; // [RQ12]
                end
                gp_pkg::FI_VSCALE1: begin
                    nxt_st.req.vscale_sel[0] = act_w; // [RQ13]
                end
                gp_pkg::FI_VSCALE2: begin
                    nxt_st.req.vscale_sel[1] = act_w; // [RQ13]
                end
                gp_pkg::FI_HW_EN1: begin
                    nxt_st.req.hw_en[0] = act_w; // [RQ13]
                end
                gp_pkg::FI_HW_EN2: begin
                    nxt_st.req.hw_en[1] = act_w; // [RQ13]
                end
                gp_pkg::FI_HW_CTL1: begin
                    nxt_st.req.hw_ctl[0] = act_w; // [RQ14]
                end
                gp_pkg::FI_HW_CTL2: begin
                    nxt_st.req.hw_ctl[1] = act_w; // [RQ14]
                end
                gp_pkg::FI_HW_CTL1_LONG: begin
                    nxt_st.req.hw_ctl[0] = act_w; // [RQ14]
                    nxt_st.req.long_db = 1'b1; // [RQ14]
                end
                gp_pkg::FI_HW_CTL2_LONG: begin
                    nxt_st.req.hw_ctl[1] = act_w; // [RQ14]
                    nxt_st.req.long_db = 1'b1; // [RQ14]
                end
                default: begin
                    nxt_st.req = '0;
                end
            endcase
        end

        // Output functions, active-high level before polarity
        case (fn_w)
            gp_pkg::FO_LEVEL: lvl = st_ff.out_lvl; // [RQ15]
            gp_pkg::FO_CLK_32K: lvl = src.clk_32k; // [RQ15]
            gp_pkg::FO_ON_STATE: lvl = src.on_state; // [RQ16]
            gp_pkg::FO_SLEEP_STATE: lvl = src.sleep_state; // [RQ16]
            gp_pkg::FO_STATE_CHANGE: lvl = src.state_change; // [RQ16]
            gp_pkg::FO_VSCALE_DONE1: lvl = src.vscale_done[0]; // [RQ17]
            gp_pkg::FO_VSCALE_DONE2: lvl = src.vscale_done[1]; // [RQ17]
            gp_pkg::FO_EXT_EN1: lvl = src.ext_en[0]; // [RQ18]
            gp_pkg::FO_EXT_EN2: lvl = src.ext_en[1]; // [RQ18]
            gp_pkg::FO_SYS_OK: lvl = src.sys_ok; // [RQ19]
            gp_pkg::FO_PWR_OK: lvl = src.pwr_ok; // [RQ19]
            gp_pkg::FO_CLK_2M: lvl = src.clk_2m; // [RQ20]
            gp_pkg::FO_AUX_RST: lvl = src.aux_rst; // [RQ20]
            default: lvl = 1'b0; // [RQ22]
        endcase
        drive = pol_w ? lvl : ~lvl; // [RQ5] [RQ22]

        // Pad drive: open drain only sinks
        if (!out_on) begin
            nxt_st.pin_oe_n = 1'b1; // [RQ7]
            nxt_st.pin_o = 1'b0;
        end else if (od_w) begin
            nxt_st.pin_oe_n = drive; // [RQ6]
            nxt_st.pin_o = 1'b0; // [RQ6]
        end else begin
            nxt_st.pin_oe_n = 1'b0; // [RQ6]
            nxt_st.pin_o = drive;
        end

        // Write channel capture
        if (aw_hit) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = awaddr;
        end
        if (w_hit) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = wdata;
            nxt_st.wstrb = wstrb;
        end
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end
        wa = st_ff.aw_got ? st_ff.awaddr : awaddr;
        wd = st_ff.w_got ? st_ff.wdata : wdata;
        ws = st_ff.w_got ? st_ff.wstrb : wstrb;
        m = {{8{ws[1]}}, {8{ws[0]}}} & gp_pkg::CFG_WMASK;

        // Write when both address and data are in
        if ((st_ff.aw_got || aw_hit) && (st_ff.w_got || w_hit)) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = gp_pkg::RESP_OKAY;
            if (wa[31:2] == gp_pkg::CFG_WORD) begin
                nxt_st.cfg = gp_pkg::cfg_t'((st_ff.cfg & ~m) | (wd[15:0] & m));
            end else if (wa[31:2] == gp_pkg::LVL_WORD) begin
                if (ws[0]) begin
                    nxt_st.out_lvl = wd[0];
                end
            end else begin
                nxt_st.bresp = gp_pkg::RESP_SLVERR;
            end
        end

        // Read channel
        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = gp_pkg::RESP_OKAY;
            if (araddr[31:2] == gp_pkg::CFG_WORD) begin
                nxt_st.rdata = {16'h0000, st_ff.cfg & gp_pkg::CFG_WMASK};
            end else if (araddr[31:2] == gp_pkg::LVL_WORD) begin
                nxt_st.rdata = {30'h0000_0000, st_ff.sync2, st_ff.out_lvl};
            end else begin
                nxt_st.rdata = 32'h0000_0000;
                nxt_st.rresp = gp_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= gp_pkg::ST_RESET; // [RQ1] [RQ4] [RQ7] [RQ8]
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence rise_armed;
        ena_w && dir_w && !edge_w && pol_w && rise_w;
    endsequence

    sequence fall_armed;
        ena_w && dir_w && !edge_w && !pol_w && fall_w;
    endsequence

    sequence any_edge_armed;
        ena_w && dir_w && edge_w && (rise_w || fall_w);
    endsequence

    a_pull_reserved_off: assert property ( // [RQ1]
        (st_ff.cfg.pull == 2'h3) |-> (!pull_up_en && !pull_down_en))
        else $error("pull enabled by reserved code");
    a_irq_rising_edge: assert property (rise_armed |=> pin_irq) // [RQ2]
        else $error("rising edge interrupt missed");
    a_irq_falling_edge: assert property (fall_armed |=> pin_irq) // [RQ2]
        else $error("falling edge interrupt missed");
    a_irq_wrong_edge: assert property ( // [RQ2]
        (ena_w && !edge_w && pol_w && fall_w) |=> !pin_irq)
        else $error("interrupt on wrong edge");
    a_irq_both_edges: assert property (any_edge_armed |=> pin_irq) // [RQ3]
        else $error("both edge interrupt missed");
    a_supply_follows: assert property ( // [RQ4]
        $changed(st_ff.cfg.dom) |-> (supply_sel == st_ff.cfg.dom))
        else $error("supply select mismatch");
    a_input_polarity: assert property ( // [RQ5]
        (ena_w && dir_w && fn_w == gp_pkg::FI_GPIO) |=> (req.gpio_level == $past(act_w)))
        else $error("input level not polarity corrected");
    a_od_never_high: assert property ( // [RQ6]
        (!pin_oe_n && $past(od_w)) |-> !pin_o)
        else $error("open drain pin driven high");
    a_disabled_float: assert property ( // [RQ7]
        !ena_w[*2] |-> pin_oe_n[*2])
        else $error("disabled pin driven");
    a_input_float: assert property (dir_w |=> pin_oe_n) // [RQ8]
        else $error("input pin driven");
    a_wdog_route: assert property ( // [RQ12]
        (ena_w && dir_w && fn_w == gp_pkg::FI_WDOG) |=> (req.wdog_kick == $past(act_w)))
        else $error("watchdog input not routed");
    a_disabled_quiet: assert property ( // [RQ21]
        !ena_w |=> (req == '0 && !pin_irq))
        else $error("disabled pin raised request");
    a_reserved_idle: assert property ( // [RQ22]
        (ena_w && !dir_w && !od_w && fn_w >= gp_pkg::FO_RSV_LO
            && fn_w <= gp_pkg::FO_RSV_HI) |=> (pin_o == !$past(pol_w)))
        else $error("reserved output not inactive");
    a_write_answer: assert property (
        ((st_ff.aw_got || aw_hit) && (st_ff.w_got || w_hit)) |=> bvalid)
        else $error("write response late");
    a_pull_exclusive: assert property (!(pull_up_en && pull_down_en)) // [RQ1]
        else $error("both pulls enabled");
    a_level_drive: assert property ( // [RQ15]
        (ena_w && !dir_w && !od_w && fn_w == gp_pkg::FO_LEVEL)
            |=> (pin_o == ($past(pol_w) ~^ $past(st_ff.out_lvl))))
        else $error("level output wrong");
    a_od_level_drive: assert property ( // [RQ6]
        (ena_w && !dir_w && od_w && fn_w == gp_pkg::FO_LEVEL)
            |=> (pin_oe_n == ($past(pol_w) ~^ $past(st_ff.out_lvl))))
        else $error("open drain level wrong");
    a_read_answer: assert property ((arvalid && arready) |=> rvalid)
        else $error("read response late");
    a_write_holds: assert property ((bvalid && !bready) |=> bvalid)
        else $error("write response dropped");
    a_read_holds: assert property (
        (rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp)))
        else $error("read response dropped");

endmodule // gp_pin_unit

//--- tb/board_model.sv
// Board-side model of the pad: pulls, outside driver, floating pattern
`timescale 1ns/100ps

module board_model (
    input wire logic clk,
    input wire logic pin_o,
    input wire logic pin_oe_n,
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    input wire logic ext_drive,
    input wire logic ext_val,
    output logic pad
);
    logic flip_ff = 1'b0;

    // Undriven, unpulled wire changes every cycle
    always_ff @(posedge clk) begin
        flip_ff <= !flip_ff;
    end

    always_comb begin
        if (!pin_oe_n) begin
            pad = pin_o;
        end else if (ext_drive) begin
            pad = ext_val;
        end else if (pull_up_en) begin
            pad = 1'b1;
        end else if (pull_down_en) begin
            pad = 1'b0;
        end else begin
            pad = flip_ff;
        end
    end
endmodule // board_model

//--- tb/tb.sv
// Self-checking bench of the general pin unit
`timescale 1ns/100ps

module tb;
    localparam logic [31:0] CFG_ADDR = {gp_pkg::CFG_WORD, 2'b00};
    localparam logic [31:0] LVL_ADDR = {gp_pkg::LVL_WORD, 2'b00};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic pin_i, pin_o, pin_oe_n, pull_up_en, pull_down_en, supply_sel, pin_irq;
    logic ext_drive = 1'b1, ext_val = 1'b0;
    gp_pkg::src_t src = '0;
    gp_pkg::req_t req, er;
    int errors = 0;
    int samples_checked = 0;
    int irq_cnt = 0;
    int base;
    logic [31:0] d;
    logic [1:0] r;

    always #20 clk = !clk;
    always @(posedge clk) if (pin_irq === 1'b1) irq_cnt++;

    gp_pin_unit i_gp_pin_unit (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pull_up_en(pull_up_en),
        .pull_down_en(pull_down_en), .supply_sel(supply_sel), .src(src), .req(req),
        .pin_irq(pin_irq));
    board_model i_board_model (.clk(clk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .ext_drive(ext_drive),
        .ext_val(ext_val), .pad(pin_i));

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic ah, wh, ag, wg, bh;
        int n;
        ag = 0;
        wg = 0;
        bh = 0;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bh && n < 50) begin
            @(negedge clk);
            ah = awready && !ag;
            wh = wready && !wg;
            bh = bvalid === 1'b1;
            resp = bresp;
            @(posedge clk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            ag |= ah;
            wg |= wh;
            n++;
        end
        bready <= 1'b0;
        if (!bh) chk(0, 1, "write hang");
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic rh, ah;
        int n;
        rh = 0;
        ah = 0;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!rh && n < 50) begin
            @(negedge clk);
            ah = arvalid && arready === 1'b1;
            rh = rvalid === 1'b1;
            v = rdata;
            resp = rresp;
            @(posedge clk);
            if (ah) arvalid <= 1'b0;
            n++;
        end
        arvalid <= 1'b0;
        rready <= 1'b0;
        if (!rh) chk(0, 1, "read hang");
    endtask

    function automatic logic [31:0] cfg(input int dir, input int pull, input int edg,
        input int pol, input int od, input int ena, input int fn);
        return {16'h0000, dir[0], pull[1:0], edg[0], 1'b0, pol[0], od[0], 1'b0, ena[0], 3'h0,
            fn[3:0]};
    endfunction

    function automatic int sidx(input int fn);
        case (fn)
            4'h8: return 6;
            4'h9: return 7;
            4'hA: return 4;
            4'hB: return 5;
            default: return (fn < 4'h5) ? 12 - fn : 15 - fn;
        endcase
    endfunction

    task automatic irq_case(input logic [31:0] c, input int e_rise, input int e_fall);
        ext_val <= 1'b0;
        wr(CFG_ADDR, c, r);
        repeat (6) @(posedge clk);
        base = irq_cnt;
        ext_val <= 1'b1;
        repeat (6) @(posedge clk);
        chk(irq_cnt - base, e_rise, "irq on rise");
        ext_val <= 1'b0;
        repeat (6) @(posedge clk);
        chk(irq_cnt - base, e_fall, "irq on fall");
    endtask

    initial begin
        #(40 * 20000);
        chk(0, 1, "watchdog");
        finish_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd(CFG_ADDR, d, r);
        chk(d, {16'h0000, gp_pkg::CFG_RESET}, "reset cfg");
        chk(r, gp_pkg::RESP_OKAY, "read okay");
        chk({pull_down_en, pull_up_en, pin_oe_n, supply_sel}, 4'hA, "reset pins");
        rd(CFG_ADDR + 32'h0000_0020, d, r);
        chk(d, 32'h0000_0000, "unmapped read data");
        chk(r, gp_pkg::RESP_SLVERR, "unmapped read");
        wr(CFG_ADDR + 32'h0000_0020, 32'hFFFF_FFFF, r);
        chk(r, gp_pkg::RESP_SLVERR, "unmapped write");
        wr(CFG_ADDR, 32'hFFFF_FFFF, r);
        chk(r, gp_pkg::RESP_OKAY, "write okay");
        rd(CFG_ADDR, d, r);
        chk(d, {16'h0000, gp_pkg::CFG_WMASK}, "cfg mask");
        chk({pull_up_en, pull_down_en, supply_sel}, 3'h1, "pull 11, supply");
        wstrb <= 4'h1;
        wr(CFG_ADDR, 32'h0000_0000, r);
        rd(CFG_ADDR, d, r);
        chk(d, 32'h0000_FE00, "low byte strobe");
        wstrb <= 4'hF;
        for (int p = 0; p < 3; p++) begin
            wr(CFG_ADDR, cfg(1, p, 0, 1, 0, 0, 4'h1), r);
            chk({pull_up_en, pull_down_en, supply_sel}, {p == 2, p == 1, 1'b0}, "pull");
        end
        for (int f = 0; f < 16; f++) begin
            wr(CFG_ADDR, cfg(1, 0, 0, 1, 0, 1, f), r);
            ext_val <= 1'b1;
            repeat (5) @(posedge clk);
            er = '0;
            er.gpio_level = f < 2;
            er.long_db = f == 0 || f == 4 || f == 14 || f == 15;
            er.pwr_onoff = f == 2;
            er.sleep_wake = f == 3 || f == 4;
            er.sleep = f == 5;
            er.pwr_on = f == 6;
            er.wdog_kick = f == 7;
            er.vscale_sel = {f == 9, f == 8};
            er.hw_en = {f == 11, f == 10};
            er.hw_ctl = {f == 13 || f == 15, f == 12 || f == 14};
            chk(req, er, "input function");
            ext_val <= 1'b0;
        end
        wr(CFG_ADDR, cfg(1, 0, 0, 0, 0, 1, 4'h1), r);
        repeat (5) @(posedge clk);
        chk(req.gpio_level, 1'b1, "active low input");
        rd(LVL_ADDR, d, r);
        chk(d[1], 1'b0, "raw pin readback");
        irq_case(cfg(1, 0, 0, 1, 0, 1, 4'h1), 1, 1);
        irq_case(cfg(1, 0, 0, 0, 0, 1, 4'h1), 0, 1);
        irq_case(cfg(1, 0, 1, 0, 0, 1, 4'h1), 1, 2);
        irq_case(cfg(1, 0, 1, 1, 0, 0, 4'h2), 0, 0);
        chk(req, '0, "disabled request");
        ext_drive <= 1'b0;
        for (int f = 0; f < 16; f++) begin
            wr(CFG_ADDR, cfg(0, 0, 0, 1, 0, 1, f), r);
            if (f == 0) begin
                wr(LVL_ADDR, 32'h1, r);
            end else begin
                src <= (f > 4 && f < 8) ? 12'hFFF : 12'h001 << sidx(f);
            end
            repeat (3) @(posedge clk);
            chk({pin_oe_n, pin_o, pin_i}, {1'b0, !(f > 4 && f < 8), !(f > 4 && f < 8)},
                "output active");
            if (f == 0) begin
                wr(LVL_ADDR, 32'h0, r);
            end else begin
                src <= ~(12'h001 << sidx(f));
            end
            repeat (3) @(posedge clk);
            chk(pin_o, 1'b0, "output idle");
        end
        src <= 12'hFFF;
        wr(CFG_ADDR, cfg(0, 0, 0, 0, 0, 1, 4'h6), r);
        repeat (3) @(posedge clk);
        chk(pin_o, 1'b1, "reserved, inverted");
        wr(LVL_ADDR, 32'h1, r);
        wr(CFG_ADDR, cfg(0, 0, 0, 0, 0, 1, 4'h0), r);
        repeat (3) @(posedge clk);
        chk(pin_o, 1'b0, "inverted level");
        wr(CFG_ADDR, cfg(0, 2, 0, 1, 1, 1, 4'h0), r);
        repeat (3) @(posedge clk);
        chk({pin_oe_n, pin_o, pin_i}, 3'h5, "open drain high");
        wr(LVL_ADDR, 32'h0, r);
        repeat (3) @(posedge clk);
        chk({pin_oe_n, pin_o, pin_i}, 3'h0, "open drain low");
        wr(CFG_ADDR, cfg(0, 0, 0, 1, 0, 0, 4'h0), r);
        repeat (3) @(posedge clk);
        chk(pin_oe_n, 1'b1, "disabled output");
        finish_test();
    end
endmodule // tb
